// file: hdl/rfc_channel.sv
// How it works
// RULE_01 - Output sum of two selected source values
// RULE_02 - Same code on both selectors counts once
// RULE_03 - Code 0 contributes zero
// RULE_04 - Code 1 analog input one, selector1 default
// RULE_05 - Code 2 analog input two, must be analog
// RULE_06 - Code 3 fixed frequency from changeover signals
// RULE_07 - Code 5 keypad up/down value, selector2 default
// RULE_08 - Code 10 repetition frequency, modes 20/21 only
// RULE_09 - Code 30 technology controller, switches it on
// RULE_10 - Code 40 electronic gear, switches gear on
// RULE_11 - Codes 2501/2502 logic block frequency outputs
// RULE_12 - Apply limits, blocking frequencies, hysteresis
// RULE_13 - Lock keypad by avoiding code 5 on both
// RULE_14 - Same behaviour in every control configuration
// RULE_15 - Sign mode: off, both, positive, inverted
// RULE_16 - Changeover pattern picks one of eight fixed
// RULE_17 - Code 20 fieldbus, code 4 digital potentiometer
// RULE_18 - Unlisted codes zero, recomputed every cycle
`timescale 1ns/100ps
`default_nettype none
`include "rfc_map.svh"

module rfc_channel #(
    parameter int FW              = 18,
    parameter int POT_TICK_CYCLES = `RFC_POT_TICK_CYCLES
) (
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire rfc_pkg::rfc_code_t  src1_sel,
    input  wire rfc_pkg::rfc_code_t  src2_sel,
    input  wire rfc_pkg::rfc_sign_t  sign_mode,
    input  wire logic [FW-1:0]       analog_input_one_value,
    input  wire logic                ain1_is_analog,
    input  wire logic [FW-1:0]       analog_input_two_value,
    input  wire logic                ain2_is_analog,
    input  wire logic                fix_wr_en,
    input  wire logic [2:0]          fix_wr_addr,
    input  wire logic [FW-1:0]       fix_wr_data,
    input  wire logic [2:0]          fix_change_pin,
    input  wire logic                key_up_pin,
    input  wire logic                key_down_pin,
    input  wire logic                pot_up_pin,
    input  wire logic                pot_down_pin,
    input  wire logic [FW-1:0]       second_digital_input,
    input  wire logic [7:0]          second_digital_input_mode,
    input  wire logic [FW-1:0]       fieldbus_ref,
    input  wire logic [FW-1:0]       techctl_value,
    input  wire logic [FW-1:0]       gear_value,
    input  wire logic [FW-1:0]       plc_freq_one,
    input  wire logic [FW-1:0]       plc_freq_two,
    input  wire logic [FW-1:0]       min_freq,
    input  wire logic [FW-1:0]       max_freq,
    input  wire logic [FW-1:0]       block_freq_one,
    input  wire logic [FW-1:0]       block_freq_two,
    input  wire logic [FW-1:0]       freq_hyst,
    output var  logic [FW-1:0]       freq_ref,
    output var  logic                techctl_on,
    output var  logic                gear_on,
    output var  logic                keypad_in_use
);
    import rfc_pkg::*;

    localparam int NP = `RFC_PIN_COUNT;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [NP-1:0] s1;
        logic [NP-1:0] s2;
        logic [NP-1:0] s3;
        logic [NP-1:0] flt;
        logic [31:0]   tick;
        logic [FW-1:0] key_pot;
        logic [FW-1:0] dig_pot;
        logic [FW:0]   sum;
        logic [FW-1:0] post;
        logic          off;
        logic          techctl;
        logic          gear;
        logic          keypad;
    } rfc_state_t;

    rfc_state_t    q, d;
    logic [FW-1:0] fix_value;
    logic [2:0]    fix_index;
    logic [NP-1:0] pins;
    logic          tick_hit;

    // Refuse widths that cannot hold +/-999.99 Hz in 0.01 Hz steps
    if (FW < 18 || FW > 30) begin : g_bad_fw
        $error("rfc_channel: FW out of range");
    end
    if (POT_TICK_CYCLES < 1) begin : g_bad_tick
        $error("rfc_channel: bad tick count");
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------

    // Pins arrive as {co3,co2,co1}, so changeover 1 is bit 0
    function automatic logic [2:0] fix_decode(input logic [2:0] co);
        case (co)                                           // [RULE_16]
            3'b000:  fix_decode = 3'h0;
            3'b001:  fix_decode = 3'h1;
            3'b011:  fix_decode = 3'h2;
            3'b010:  fix_decode = 3'h3;
            3'b110:  fix_decode = 3'h4;
            3'b111:  fix_decode = 3'h5;
            3'b101:  fix_decode = 3'h6;
            3'b100:  fix_decode = 3'h7;
            default: fix_decode = 3'h0;
        endcase
    endfunction : fix_decode

    // Up/down ramp, held inside +/- max frequency
    function automatic logic [FW-1:0] pot_step(
        input logic [FW-1:0] cur,
        input logic          up,
        input logic          dn,
        input logic [FW-1:0] lim
    );
        logic signed [FW:0] v;
        logic signed [FW:0] hi;
        v  = {cur[FW-1], cur};
        hi = {1'b0, lim};
        if (up && !dn) v = v + (FW+1)'(`RFC_POT_STEP);
        if (dn && !up) v = v - (FW+1)'(`RFC_POT_STEP);
        if (v > hi) v = hi;
        if (v < -hi) v = -hi;
        pot_step = v[FW-1:0];
    endfunction : pot_step

    // Sign-extended value of one selector code
    function automatic logic [FW:0] src_value(input logic [11:0] code);
        logic [FW-1:0] v;
        v = '0;
        case (code)
            RFC_SRC_ZERO:   v = '0;                         // [RULE_03]
            RFC_SRC_AIN1:                                   // [RULE_04]
                v = ain1_is_analog ? analog_input_one_value : '0;
            RFC_SRC_AIN2:                                   // [RULE_05]
                v = ain2_is_analog ? analog_input_two_value : '0;
            RFC_SRC_FIXED:  v = fix_value;                  // [RULE_06]
            RFC_SRC_MOTPOT: v = q.dig_pot;                  // [RULE_17]
            RFC_SRC_KEYPAD: v = q.key_pot;                  // [RULE_07]
            RFC_SRC_RPTF: begin                             // [RULE_08]
                if (second_digital_input_mode == `RFC_RPT_SINGLE ||
                    second_digital_input_mode == `RFC_RPT_DOUBLE) begin
                    v = second_digital_input;
                end
            end
            RFC_SRC_FBUS:   v = fieldbus_ref;               // [RULE_17]
            RFC_SRC_TECH:   v = techctl_value;              // [RULE_09]
            RFC_SRC_GEAR:   v = gear_value;                 // [RULE_10]
            RFC_SRC_PLC1:   v = plc_freq_one;               // [RULE_11]
            RFC_SRC_PLC2:   v = plc_freq_two;               // [RULE_11]
            default:        v = '0;                         // [RULE_18]
        endcase
        src_value = {v[FW-1], v};
    endfunction : src_value

    // Saturate a wide signed value to +/- limit
    function automatic logic [FW-1:0] sat(
        input logic [FW:0]   v,
        input logic [FW-1:0] lim
    );
        logic signed [FW:0] sv;
        logic signed [FW:0] hi;
        sv = v;
        hi = {1'b0, lim};
        if (sv > hi) sv = hi;
        if (sv < -hi) sv = -hi;
        sat = sv[FW-1:0];
    endfunction : sat

    // ------------------------------------------------------------------
    // Pin gathering
    // ------------------------------------------------------------------

    // Outside pins enter one synchroniser chain
    always_comb begin
        pins = '0;
        pins[`RFC_PIN_FIX_LSB +: 3] = fix_change_pin;
        pins[`RFC_PIN_KEY_UP]       = key_up_pin;
        pins[`RFC_PIN_KEY_DN]       = key_down_pin;
        pins[`RFC_PIN_POT_UP]       = pot_up_pin;
        pins[`RFC_PIN_POT_DN]       = pot_down_pin;
    end

    assign fix_index = fix_decode(q.flt[`RFC_PIN_FIX_LSB +: 3]);
    assign tick_hit  = (q.tick == 32'(POT_TICK_CYCLES - 1));

    // ------------------------------------------------------------------
    // Fixed frequency store
    // ------------------------------------------------------------------
    rfc_fixed_bank #(
        .W (FW)
    ) u_fixed (
        .clk     (clk),
        .rst_n   (rst_n),
        .wr_en   (fix_wr_en),
        .wr_addr (fix_wr_addr),
        .wr_data (fix_wr_data),
        .rd_addr (fix_index),                               // [RULE_06]
        .rd_data (fix_value)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------

    // No configuration input exists, so every configuration sees one path
    always_comb begin                                       // [RULE_14]
        logic [FW:0] v1;
        logic [FW:0] v2;
        d  = q;
        v1 = src_value(src1_sel);
        v2 = src_value(src2_sel);

        // Three-stage synchroniser; a level counts once stages 2 and 3 agree
        d.s1 = pins;
        d.s2 = q.s1;
        d.s3 = q.s2;
        for (int i = 0; i < NP; i++) begin
            if (q.s2[i] == q.s3[i]) d.flt[i] = q.s3[i];
        end

        // Free-running step timer; ramps move once per interval
        d.tick = tick_hit ? '0 : q.tick + 32'h1;
        if (tick_hit) begin
            d.key_pot = pot_step(q.key_pot, q.flt[`RFC_PIN_KEY_UP],
                                 q.flt[`RFC_PIN_KEY_DN], max_freq); // [RULE_07]
            d.dig_pot = pot_step(q.dig_pot, q.flt[`RFC_PIN_POT_UP],
                                 q.flt[`RFC_PIN_POT_DN], max_freq); // [RULE_17]
        end

        // Summing point, a shared code is taken once, every cycle
        if (src1_sel == src2_sel) begin
            d.sum = v1;                                     // [RULE_02]
        end else begin
            d.sum = v1 + v2;                                // [RULE_01] [RULE_18]
        end

        // Sign post-processing before the limiter
        d.off = 1'b0;
        case (sign_mode)                                    // [RULE_15]
            RFC_SIGN_OFF: begin
                d.post = '0;
                d.off  = 1'b1;
            end
            RFC_SIGN_BOTH: d.post = sat(q.sum, max_freq);
            RFC_SIGN_POS: begin
                d.post = q.sum[FW] ? '0 : sat(q.sum, max_freq);
            end
            RFC_SIGN_INV: d.post = FW'(-sat(q.sum, max_freq));
            default: d.post = '0;
        endcase

        // Functions driven by the selector choice
        d.techctl = (src1_sel == RFC_SRC_TECH) ||
                    (src2_sel == RFC_SRC_TECH);             // [RULE_09]
        d.gear    = (src1_sel == RFC_SRC_GEAR) ||
                    (src2_sel == RFC_SRC_GEAR);             // [RULE_10]
        // Keypad lock is simply neither selector on the keypad code
        d.keypad  = (src1_sel == RFC_SRC_KEYPAD) ||
                    (src2_sel == RFC_SRC_KEYPAD);           // [RULE_13]
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // Limits, blocking frequencies and hysteresis
    // ------------------------------------------------------------------
    rfc_limiter #(
        .FW (FW)
    ) u_limit (
        .clk      (clk),
        .rst_n    (rst_n),
        .ref_in   (q.post),
        .off      (q.off),
        .min_freq (min_freq),
        .max_freq (max_freq),
        .block1   (block_freq_one),
        .block2   (block_freq_two),
        .hyst     (freq_hyst),
        .ref_out  (freq_ref)                                // [RULE_12]
    );

    // Status outputs straight from flip-flops
    assign techctl_on    = q.techctl;
    assign gear_on       = q.gear;
    assign keypad_in_use = q.keypad;

endmodule : rfc_channel
`default_nettype wire

// file: hdl/rfc_fixed_bank.sv
`timescale 1ns/100ps
`default_nettype none
`include "rfc_map.svh"

module rfc_fixed_bank #(
    parameter int W = 18
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         wr_en,
    input  wire logic [2:0]   wr_addr,
    input  wire logic [W-1:0] wr_data,
    input  wire logic [2:0]   rd_addr,
    output var  logic [W-1:0] rd_data
);
    import rfc_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0][W-1:0] mem;
        logic [W-1:0]      rdata;
    } rfc_bank_t;

    rfc_bank_t q, d;

    if (W < 16 || W > 30) begin : g_bad_w
        $error("rfc_fixed_bank: W out of range");
    end

    // Read sees the contents before this cycle's write, data registered one cycle after the address
    always_comb begin
        d = q;
        if (wr_en) begin
            d.mem[wr_addr] = wr_data;
        end
        d.rdata = q.mem[rd_addr];
    end

    // Reset loads the factory fixed frequencies
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q.mem[0] <= W'(`RFC_FIX1_RST);
            q.mem[1] <= W'(`RFC_FIX2_RST);
            q.mem[2] <= W'(`RFC_FIX3_RST);
            q.mem[3] <= W'(`RFC_FIX4_RST);
            q.mem[4] <= W'(`RFC_FIX5_RST);
            q.mem[5] <= W'(`RFC_FIX6_RST);
            q.mem[6] <= W'(`RFC_FIX7_RST);
            q.mem[7] <= W'(`RFC_FIX8_RST);
            q.rdata  <= '0;
        end else begin
            q <= d;
        end
    end

    assign rd_data = q.rdata;

endmodule : rfc_fixed_bank
`default_nettype wire

// file: hdl/rfc_limiter.sv
`timescale 1ns/100ps
`default_nettype none

module rfc_limiter #(
    parameter int FW = 18
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic [FW-1:0] ref_in,
    input  wire logic          off,
    input  wire logic [FW-1:0] min_freq,
    input  wire logic [FW-1:0] max_freq,
    input  wire logic [FW-1:0] block1,
    input  wire logic [FW-1:0] block2,
    input  wire logic [FW-1:0] hyst,
    output var  logic [FW-1:0] ref_out
);
    import rfc_pkg::*;

    typedef struct packed {
        logic [FW-1:0] out;
    } rfc_lim_t;

    rfc_lim_t q, d;

    if (FW < 16 || FW > 30) begin : g_bad_fw
        $error("rfc_limiter: FW out of range");
    end

    // Two's complement magnitude, min value cannot occur after clamping
    function automatic logic [FW-1:0] mag_of(input logic [FW-1:0] v);
        mag_of = v[FW-1] ? FW'(-v) : v;
    endfunction : mag_of

    // Skip a band around a blocking frequency; side follows last output
    function automatic logic [FW-1:0] skip_band(
        input logic [FW-1:0] m,
        input logic [FW-1:0] prev,
        input logic [FW-1:0] b,
        input logic [FW-1:0] h
    );
        logic [FW:0] lo;
        logic [FW:0] hi;
        lo = ({1'b0, b} > {1'b0, h}) ? {1'b0, b} - {1'b0, h} : '0;
        hi = {1'b0, b} + {1'b0, h};
        skip_band = m;
        if (b != '0 && {1'b0, m} > lo && {1'b0, m} < hi) begin
            skip_band = (prev >= b) ? hi[FW-1:0] : lo[FW-1:0];
        end
    endfunction : skip_band

    // Limits, then blocking bands with hysteresis, then sign back on
    always_comb begin
        logic [FW-1:0] m;
        logic          neg;
        m   = mag_of(ref_in);
        neg = ref_in[FW-1];
        d   = q;
        if (m > max_freq) m = max_freq;                     // [RULE_12]
        if (m < min_freq) m = min_freq;                     // [RULE_12]
        m = skip_band(m, mag_of(q.out), block1, hyst);      // [RULE_12]
        m = skip_band(m, mag_of(q.out), block2, hyst);      // [RULE_12]
        d.out = off ? '0 : (neg ? FW'(-m) : m);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign ref_out = q.out;

endmodule : rfc_limiter
`default_nettype wire

// file: hdl/rfc_map.svh
`ifndef RFC_MAP_SVH
`define RFC_MAP_SVH

// --------------------
// Clock and timing
// --------------------
`define RFC_CLK_PERIOD_NS   10
// Motor potentiometer step interval in ms while a key is held
`define RFC_POT_STEP_MS     10
`define RFC_POT_TICK_CYCLES ((`RFC_POT_STEP_MS * 1000000) / `RFC_CLK_PERIOD_NS)
// Motor potentiometer step size in 0.01 Hz
`define RFC_POT_STEP        10

// --------------------
// Repetition frequency input modes
// --------------------
`define RFC_RPT_SINGLE      8'd20
`define RFC_RPT_DOUBLE      8'd21

// --------------------
// Fixed frequency reset values in 0.01 Hz
// --------------------
`define RFC_FIX1_RST        0
`define RFC_FIX2_RST        1000
`define RFC_FIX3_RST        2500
`define RFC_FIX4_RST        5000
`define RFC_FIX5_RST        500
`define RFC_FIX6_RST        1000
`define RFC_FIX7_RST        2500
`define RFC_FIX8_RST        5000

// --------------------
// Pin synchroniser bit positions
// --------------------
`define RFC_PIN_FIX_LSB     0
`define RFC_PIN_KEY_UP      3
`define RFC_PIN_KEY_DN      4
`define RFC_PIN_POT_UP      5
`define RFC_PIN_POT_DN      6
`define RFC_PIN_COUNT       7

`endif

// file: hdl/rfc_pkg.sv
package rfc_pkg;

    // --------------------
    // Source selector codes
    // --------------------
    typedef logic [11:0] rfc_code_t;

    typedef enum logic [11:0] {
        RFC_SRC_ZERO   = 12'h000,
        RFC_SRC_AIN1   = 12'h001,
        RFC_SRC_AIN2   = 12'h002,
        RFC_SRC_FIXED  = 12'h003,
        RFC_SRC_MOTPOT = 12'h004,
        RFC_SRC_KEYPAD = 12'h005,
        RFC_SRC_RPTF   = 12'h00a,
        RFC_SRC_FBUS   = 12'h014,
        RFC_SRC_TECH   = 12'h01e,
        RFC_SRC_GEAR   = 12'h028,
        RFC_SRC_PLC1   = 12'h9c5,
        RFC_SRC_PLC2   = 12'h9c6
    } rfc_src_t;

    // --------------------
    // Sign post-processing modes
    // --------------------
    typedef enum logic [1:0] {
        RFC_SIGN_OFF  = 2'h0,
        RFC_SIGN_BOTH = 2'h1,
        RFC_SIGN_POS  = 2'h2,
        RFC_SIGN_INV  = 2'h3
    } rfc_sign_t;

endpackage : rfc_pkg

// file: tb/rfc_far_model.sv
`timescale 1ns/100ps
`default_nettype none

// Far-side sources: second analog input, pulse input, bus, controllers
module rfc_far_model #(
    parameter int FW = 18
) (
    output logic [FW-1:0] ain2_val,
    output logic          ain2_analog,
    output logic [FW-1:0] rpt_val,
    output logic [FW-1:0] fbus_val,
    output logic [FW-1:0] tech_val,
    output logic [FW-1:0] gear_val,
    output logic [FW-1:0] plc1_val,
    output logic [FW-1:0] plc2_val
);
    // --------------------
    // Steady values; distinct so a wrong source pick shows at once
    // --------------------
    assign ain2_val    = FW'(-1200);
    assign ain2_analog = 1'b1;       // Input two set up as analog
    assign rpt_val     = FW'(700);
    assign fbus_val    = FW'(1500);
    assign tech_val    = FW'(-2000);
    assign gear_val    = FW'(3000);
    assign plc1_val    = FW'(400);
    assign plc2_val    = FW'(-4500);
endmodule : rfc_far_model

`default_nettype wire

// file: tb/rfc_props.sv
`timescale 1ns/100ps
`default_nettype none

module rfc_props
    import rfc_pkg::*;
#(
    parameter int FW = 18
) (
    input wire logic              clk,
    input wire logic              rst_n,
    input wire rfc_pkg::rfc_code_t src1_sel,
    input wire rfc_pkg::rfc_code_t src2_sel,
    input wire rfc_pkg::rfc_sign_t sign_mode,
    input wire logic [FW-1:0]     min_freq,
    input wire logic [FW-1:0]     max_freq,
    input wire logic [FW-1:0]     block_freq_one,
    input wire logic [FW-1:0]     freq_hyst,
    input wire logic [FW-1:0]     freq_ref,
    input wire logic              techctl_on,
    input wire logic              gear_on,
    input wire logic              keypad_in_use
);
    // --------------------
    // Helpers
    // --------------------
    // Edges since reset release, held at seven
    logic [2:0] age_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) age_q <= 3'h0;
        else if (age_q != 3'h7) age_q <= age_q + 3'h1;
    end

    function automatic logic [FW-1:0] mag(input logic [FW-1:0] v);
        return v[FW-1] ? -v : v;
    endfunction : mag

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // --------------------
    // Properties
    // --------------------
    chk_tech_flag : assert property (
        age_q > 3'h1 |-> techctl_on ==
        $past(src1_sel == RFC_SRC_TECH || src2_sel == RFC_SRC_TECH))
        else $error("tech controller flag wrong");
    chk_gear_flag : assert property (
        age_q > 3'h1 |-> gear_on ==
        $past(src1_sel == RFC_SRC_GEAR || src2_sel == RFC_SRC_GEAR))
        else $error("gear flag wrong");
    chk_keypad_flag : assert property (
        age_q > 3'h1 |-> keypad_in_use ==
        $past(src1_sel == RFC_SRC_KEYPAD || src2_sel == RFC_SRC_KEYPAD))
        else $error("keypad flag wrong");
    chk_sign_off : assert property (
        (sign_mode == RFC_SIGN_OFF)[*3] |=> freq_ref == '0)
        else $error("off mode not zero");
    chk_sign_pos : assert property (
        (sign_mode == RFC_SIGN_POS)[*3] |=> !freq_ref[FW-1])
        else $error("positive mode gave negative");
    chk_max_limit : assert property (
        (sign_mode != RFC_SIGN_OFF)[*3] |=> mag(freq_ref) <= max_freq)
        else $error("above maximum");
    chk_min_limit : assert property (
        (sign_mode != RFC_SIGN_OFF)[*3] |=> mag(freq_ref) >= min_freq)
        else $error("below minimum");
    chk_block_band : assert property (
        age_q > 3'h3 && block_freq_one != '0 && $stable(block_freq_one)
        |-> !(mag(freq_ref) > block_freq_one - freq_hyst &&
              mag(freq_ref) < block_freq_one + freq_hyst))
        else $error("inside blocking band");

    cov_gear : cover property (gear_on);
    cov_keypad : cover property (keypad_in_use);
    cov_invert : cover property ((sign_mode == RFC_SIGN_INV)[*3]);
endmodule : rfc_props

bind rfc_channel rfc_props #(.FW(FW)) u_props (
    .clk(clk), .rst_n(rst_n), .src1_sel(src1_sel), .src2_sel(src2_sel),
    .sign_mode(sign_mode), .min_freq(min_freq), .max_freq(max_freq),
    .block_freq_one(block_freq_one), .freq_hyst(freq_hyst),
    .freq_ref(freq_ref), .techctl_on(techctl_on), .gear_on(gear_on),
    .keypad_in_use(keypad_in_use));

`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    import rfc_pkg::*;
    localparam int FW = 18;
    logic clk, rst_n, ia1, ia2, fwe, ku, kd, pu, pd, tco, gon, kiu;
    rfc_code_t s1, s2;
    rfc_sign_t sm;
    logic [FW-1:0] a1, a2, fwd, sdi, fb, tv, gv, p1, p2, b1, b2, hy, fr;
    logic [2:0] fwa, fcp;
    logic [7:0] sdm;
    int failures, n_tests, cyc;
    localparam rfc_code_t CODES [13] = '{12'h000, 12'h001, 12'h002,
        12'h003, 12'h004, 12'h005, 12'h00a, 12'h014, 12'h01e, 12'h028,
        12'h9c5, 12'h9c6, 12'h007};
    localparam int VALS [13] = '{0, 1000, -1200, 2500, 0, 0, 700, 1500,
        -2000, 3000, 400, -4500, 0};

    rfc_channel #(.FW(FW), .POT_TICK_CYCLES(4)) uut (
        .clk(clk), .rst_n(rst_n), .src1_sel(s1), .src2_sel(s2),
        .sign_mode(sm), .analog_input_one_value(a1), .ain1_is_analog(ia1),
        .analog_input_two_value(a2), .ain2_is_analog(ia2),
        .fix_wr_en(fwe), .fix_wr_addr(fwa), .fix_wr_data(fwd),
        .fix_change_pin(fcp), .key_up_pin(ku), .key_down_pin(kd),
        .pot_up_pin(pu), .pot_down_pin(pd), .second_digital_input(sdi),
        .second_digital_input_mode(sdm), .fieldbus_ref(fb),
        .techctl_value(tv), .gear_value(gv), .plc_freq_one(p1),
        .plc_freq_two(p2), .min_freq(FW'(350)), .max_freq(FW'(5000)),
        .block_freq_one(b1), .block_freq_two(b2), .freq_hyst(hy),
        .freq_ref(fr), .techctl_on(tco), .gear_on(gon),
        .keypad_in_use(kiu));

    rfc_far_model #(.FW(FW)) u_far (.ain2_val(a2), .ain2_analog(ia2),
        .rpt_val(sdi), .fbus_val(fb), .tech_val(tv), .gear_val(gv),
        .plc1_val(p1), .plc2_val(p2));

    // --------------------
    // Clock and hang guard
    // --------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            failures++;
            end_of_test();
        end
    end

    // --------------------
    // Tasks
    // --------------------
    task automatic check(input logic [FW-1:0] got, input logic [FW-1:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // Limit stage without bands: magnitude to [min,max], sign kept
    function automatic logic [FW-1:0] lim(input int v);
        int m;
        m = (v < 0) ? -v : v;
        if (m > 5000) m = 5000;
        if (m < 350) m = 350;
        return (v < 0) ? FW'(-m) : FW'(m);
    endfunction : lim

    // Ten cycles covers pin filter plus three pipeline stages
    task automatic go(input rfc_code_t c1, input rfc_code_t c2,
                      input rfc_sign_t m, input logic [FW-1:0] exp);
        @(negedge clk);
        s1 = c1;
        s2 = c2;
        sm = m;
        repeat (10) @(negedge clk);
        check(fr, exp);
    endtask : go

    task automatic hold(ref logic pin);
        pin = 1'b1;
        repeat (400) @(negedge clk);
        pin = 1'b0;
        repeat (10) @(negedge clk);
    endtask : hold

    task end_of_test;
        $display("tests=%0d failures=%0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test

    // --------------------
    // Main sequence
    // --------------------
    initial begin
        {rst_n, fwe, ku, kd, pu, pd, fwa, fwd, b1, b2} = '0;
        {s1, s2, sm, cyc, failures, n_tests} = '0;
        ia1 = 1'b1;
        a1 = FW'(1000);
        fcp = 3'b011;
        sdm = 8'h14;
        hy = FW'(100);
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        for (int i = 0; i < 26; i++) begin
            go(i[0] ? CODES[i/2] : 12'h000, i[0] ? 12'h000 : CODES[i/2],
               RFC_SIGN_BOTH, lim(VALS[i/2]));
            check(tco, CODES[i/2] == 12'h01e);
            check(gon, CODES[i/2] == 12'h028);
            check(kiu, CODES[i/2] == 12'h005);
        end
        go(12'h001, 12'h001, RFC_SIGN_BOTH, lim(1000));
        go(12'h001, 12'h014, RFC_SIGN_BOTH, lim(2500));
        go(12'h003, 12'h028, RFC_SIGN_BOTH, lim(5500));
        go(12'h002, 12'h000, RFC_SIGN_OFF, '0);
        go(12'h002, 12'h000, RFC_SIGN_POS, lim(0));
        go(12'h002, 12'h000, RFC_SIGN_INV, lim(1200));
        ia1 = 1'b0;
        sdm = 8'h16;
        go(12'h001, 12'h00a, RFC_SIGN_BOTH, lim(0));
        ia1 = 1'b1;
        sdm = 8'h15;
        go(12'h000, 12'h00a, RFC_SIGN_BOTH, lim(700));
        // Changeover pins hold co1 in bit 0
        fcp = 3'b000;
        go(12'h003, 12'h000, RFC_SIGN_BOTH, lim(0));
        fcp = 3'b010;
        go(12'h003, 12'h000, RFC_SIGN_BOTH, lim(5000));
        fcp = 3'b110;
        go(12'h003, 12'h000, RFC_SIGN_BOTH, lim(500));
        {fwe, fwa, fwd} = {1'b1, 3'h1, FW'(-800)};
        @(negedge clk);
        fwe = 1'b0;
        fcp = 3'b001;
        go(12'h003, 12'h000, RFC_SIGN_BOTH, lim(-800));
        // Band 1900..2100; side depends on where the output came from
        b1 = FW'(2000);
        a1 = FW'(2050);
        go(12'h001, 12'h000, RFC_SIGN_BOTH, FW'(1900));
        a1 = FW'(2500);
        go(12'h001, 12'h000, RFC_SIGN_BOTH, lim(2500));
        {b1, b2, a1} = {FW'(0), FW'(2000), FW'(2050)};
        go(12'h001, 12'h000, RFC_SIGN_BOTH, FW'(2100));
        b2 = '0;
        go(12'h005, 12'h000, RFC_SIGN_BOTH, lim(0));
        hold(ku);
        check(fr >= 950 && fr <= 1050, 1'b1);
        go(12'h004, 12'h001, RFC_SIGN_BOTH, lim(2050));
        check(kiu, 1'b0); // Keypad locked out
        s2 = 12'h000;
        hold(pd);
        check($signed(fr) >= -1050 && $signed(fr) <= -950, 1'b1);
        rst_n = 1'b0;
        @(negedge clk);
        check(fr, '0);
        rst_n = 1'b1;
        go(12'h004, 12'h000, RFC_SIGN_BOTH, lim(0));
        end_of_test();
    end
endmodule : tb_top

`default_nettype wire
